/* logic/temp_tach_defines.svh */
`ifndef TEMP_TACH_DEFINES_SVH
`define TEMP_TACH_DEFINES_SVH
// Function
// - The second fan's count low byte (bits 7..0) reads at 55h and cannot be written.
// - The remote temperature high byte holds the sign in bit 7 and weights 64 down to 1 in bits 6..0.
// - The remote temperature low byte holds 0.5, 0.25, 0.125 in bits 7..5 and zeros in bits 4..0.
// - The local temperature uses the same two-byte format at 58h and 59h.
// - Reading the alarm status clears its alarm bits, and a fault still present sets its bit again.
// - Status bit 7 sets when programming the nonvolatile memory fails.
// - Status bit 7 clears only through a successful write followed by a reset, never by a read.
// - Status bit 6 sets on an open or shorted remote diode and is zero by default.
// - A remote diode fault never drives the alert output.
// - Status bit 5 sets only when the die temperature is strictly above the local high set point.
// - Status bit 4 sets only when the local temperature is strictly above the local overtemperature point.
// - Status bits 3 and 2 set when the remote temperature is strictly above the remote high and overtemperature points.
// - Status bits 1 and 0 flag the second and first fan failing.
// - The second fan's count high byte (bits 15..8) reads at 54h.

`define ADDR_FAN2_HIGH    8'h54
`define ADDR_FAN2_LOW     8'h55
`define ADDR_REMOTE_HIGH  8'h56
`define ADDR_REMOTE_LOW   8'h57
`define ADDR_LOCAL_HIGH   8'h58
`define ADDR_LOCAL_LOW    8'h59
`define ADDR_STATUS       8'h5a

`define BIT_PROG_CORRUPT  7
`define BIT_DIODE_FAULT   6
`define BIT_LOCAL_HIGH    5
`define BIT_LOCAL_OT      4
`define BIT_REMOTE_HIGH   3
`define BIT_REMOTE_OT     2
`define BIT_FAN2_FAIL     1
`define BIT_FAN1_FAIL     0

`define RESET_BYTE        8'h00
`define RESET_ALARMS      7'h00
`define RESET_COUNT       16'h0000
`define RESET_TEMP        11'h000
`define LOW_PAD_ZERO      5'h00
`define SETPOINT_FRAC     3'h0
`endif

/* logic/temp_tach_pkg.sv */
package temp_tach_pkg;
  typedef struct packed {
    logic [15:0] fan2_count;
    logic [10:0] remote_temp;
    logic [10:0] local_temp;
  } meas_t;

  typedef struct packed {
    logic [7:0] local_high;
    logic [7:0] local_ot;
    logic [7:0] remote_high;
    logic [7:0] remote_ot;
  } setpoint_t;

  typedef struct packed {
    logic       remote_diode_fault;
    logic [1:0] fan_fail;
  } fault_t;
endpackage

/* logic/temp_tach_readout_status.sv */
`timescale 1ns/1ns
`include "temp_tach_defines.svh"
module temp_tach_readout_status
  import temp_tach_pkg::*;
#(
  parameter int TEMP_W  = 11,
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Measurement results
  input  wire meas_t      meas_i,
  input  wire logic       meas_valid_i,
  // Thresholds and fault conditions
  input  wire setpoint_t  setpoint_i,
  input  wire fault_t     fault_i,
  // Nonvolatile memory status
  input  wire logic       nvm_write_done_i,
  input  wire logic       nvm_write_error_i,
  input  wire logic       nvm_boot_corrupt_i,
  // Register read port
  input  wire logic       rd_en_i,
  input  wire logic [7:0] rd_addr_i,
  output logic      [7:0] rd_data_o,
  output logic            rd_valid_o,
  // Alert pin level
  output logic            alert_o
);

  // Refused while elaborating, so a wrong width never reaches a netlist
  if (TEMP_W != 11 || COUNT_W != 16) begin : g_width_check
    $error("Register byte layout only serves an 11-bit temperature and a 16-bit count");
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Live measurement registers
  logic [15:0] fan2_count_reg;
  logic [15:0] fan2_count_next;
  logic [10:0] remote_temp_reg;
  logic [10:0] remote_temp_next;
  logic [10:0] local_temp_reg;
  logic [10:0] local_temp_next;

  always_comb begin
    fan2_count_next  = fan2_count_reg;
    remote_temp_next = remote_temp_reg;
    local_temp_next  = local_temp_reg;
    if (meas_valid_i) begin
      fan2_count_next  = meas_i.fan2_count;
      remote_temp_next = meas_i.remote_temp;
      local_temp_next  = meas_i.local_temp;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fan2_count_reg  <= `RESET_COUNT;
      remote_temp_reg <= `RESET_TEMP;
      local_temp_reg  <= `RESET_TEMP;
    end else begin
      fan2_count_reg  <= fan2_count_next;
      remote_temp_reg <= remote_temp_next;
      local_temp_reg  <= local_temp_next;
    end
  end

  // Byte views of each pair; index 0 fan, 1 remote, 2 local
  logic [7:0] high_byte [3];
  logic [7:0] low_live  [3];
  logic [7:0] high_addr [3];
  logic [7:0] low_addr  [3];
  logic [7:0] low_snap_reg   [3];
  logic [7:0] low_snap_next  [3];
  logic [2:0] snap_valid_reg;
  logic [2:0] snap_valid_next;

  assign high_byte[0] = fan2_count_reg[15:8];
  assign low_live[0]  = fan2_count_reg[7:0];
  assign high_byte[1] = remote_temp_reg[10:3];
  assign low_live[1]  = {remote_temp_reg[2:0], `LOW_PAD_ZERO};
  assign high_byte[2] = local_temp_reg[10:3];
  assign low_live[2]  = {local_temp_reg[2:0], `LOW_PAD_ZERO};
  assign high_addr[0] = `ADDR_FAN2_HIGH;
  assign low_addr[0]  = `ADDR_FAN2_LOW;
  assign high_addr[1] = `ADDR_REMOTE_HIGH;
  assign low_addr[1]  = `ADDR_REMOTE_LOW;
  assign high_addr[2] = `ADDR_LOCAL_HIGH;
  assign low_addr[2]  = `ADDR_LOCAL_LOW;

  // A high-byte read freezes the low byte so a later update cannot tear the pair
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pair
      always_comb begin
        low_snap_next[p]   = low_snap_reg[p];
        snap_valid_next[p] = snap_valid_reg[p];
        if (rd_en_i && rd_addr_i == high_addr[p]) begin
          low_snap_next[p]   = low_live[p];
          snap_valid_next[p] = 1'b1;
        end else if (rd_en_i && rd_addr_i == low_addr[p]) begin
          snap_valid_next[p] = 1'b0;
        end
      end

      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          low_snap_reg[p]   <= `RESET_BYTE;
          snap_valid_reg[p] <= 1'b0;
        end else begin
          low_snap_reg[p]   <= low_snap_next[p];
          snap_valid_reg[p] <= snap_valid_next[p];
        end
      end
    end
  endgenerate

  // Fault conditions
  function automatic logic above_point(input logic [10:0] temp, input logic [7:0] point);
    above_point = $signed(temp) > $signed({point, `SETPOINT_FRAC});
  endfunction

  logic [6:0] cond;
  always_comb begin
    cond                   = `RESET_ALARMS;
    cond[`BIT_DIODE_FAULT] = fault_i.remote_diode_fault;
    cond[`BIT_LOCAL_HIGH]  = above_point(local_temp_reg, setpoint_i.local_high);
    cond[`BIT_LOCAL_OT]    = above_point(local_temp_reg, setpoint_i.local_ot);
    cond[`BIT_REMOTE_HIGH] = above_point(remote_temp_reg, setpoint_i.remote_high);
    cond[`BIT_REMOTE_OT]   = above_point(remote_temp_reg, setpoint_i.remote_ot);
    cond[`BIT_FAN2_FAIL]   = fault_i.fan_fail[1];
    cond[`BIT_FAN1_FAIL]   = fault_i.fan_fail[0];
  end

  // Alarm status, program-corrupt flag and alert
  logic       status_read;
  logic [6:0] alarm_reg;
  logic [6:0] alarm_next;
  logic       corrupt_reg;
  logic       corrupt_next;
  logic       alert_next;

  assign status_read = rd_en_i && rd_addr_i == `ADDR_STATUS;

  always_comb begin
    // A fault present in the clearing cycle keeps its bit set
    alarm_next = (status_read ? `RESET_ALARMS : alarm_reg) | cond;
    // Only reset can clear it; the NVM reports whether its last write left it corrupt
    corrupt_next = corrupt_reg | (nvm_write_done_i & nvm_write_error_i);
    // Diode fault deliberately left out of the alert
    alert_next = alarm_next[`BIT_LOCAL_HIGH] | alarm_next[`BIT_REMOTE_HIGH];
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      alarm_reg   <= `RESET_ALARMS;
      corrupt_reg <= nvm_boot_corrupt_i;
      alert_o     <= 1'b0;
    end else begin
      alarm_reg   <= alarm_next;
      corrupt_reg <= corrupt_next;
      alert_o     <= alert_next;
    end
  end

  // Read port; writes do not exist, unmapped addresses read zero
  logic [7:0] rd_data_next;
  always_comb begin
    rd_data_next = `RESET_BYTE;
    unique case (rd_addr_i)
      `ADDR_FAN2_HIGH:   rd_data_next = high_byte[0];
      `ADDR_FAN2_LOW:    rd_data_next = snap_valid_reg[0] ? low_snap_reg[0] : low_live[0];
      `ADDR_REMOTE_HIGH: rd_data_next = high_byte[1];
      `ADDR_REMOTE_LOW:  rd_data_next = snap_valid_reg[1] ? low_snap_reg[1] : low_live[1];
      `ADDR_LOCAL_HIGH:  rd_data_next = high_byte[2];
      `ADDR_LOCAL_LOW:   rd_data_next = snap_valid_reg[2] ? low_snap_reg[2] : low_live[2];
      `ADDR_STATUS:      rd_data_next = {corrupt_reg, alarm_reg};
      default:           rd_data_next = `RESET_BYTE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_data_o  <= `RESET_BYTE;
      rd_valid_o <= 1'b0;
    end else begin
      rd_data_o  <= rd_en_i ? rd_data_next : `RESET_BYTE;
      rd_valid_o <= rd_en_i;
    end
  end

  sequence s_fan_high_read;
    rd_en_i && rd_addr_i == `ADDR_FAN2_HIGH;
  endsequence

  sequence s_fan_low_read;
    rd_en_i && rd_addr_i == `ADDR_FAN2_LOW;
  endsequence

  a_fan_low_live: assert property (
    rd_en_i && rd_addr_i == `ADDR_FAN2_LOW && !snap_valid_reg[0]
    |=> rd_valid_o && rd_data_o == $past(fan2_count_reg[7:0]))
    else $error("fan2 low byte read wrong");

  a_fan_high_byte: assert property (
    s_fan_high_read |=> rd_valid_o && rd_data_o == $past(fan2_count_reg[15:8]))
    else $error("fan2 high byte read wrong");

  a_remote_high_byte: assert property (
    rd_en_i && rd_addr_i == `ADDR_REMOTE_HIGH |=> rd_data_o == $past(remote_temp_reg[10:3]))
    else $error("remote high byte read wrong");

  a_temp_low_pad: assert property (
    rd_valid_o && ($past(rd_addr_i) == `ADDR_REMOTE_LOW || $past(rd_addr_i) == `ADDR_LOCAL_LOW)
    |-> rd_data_o[4:0] == `LOW_PAD_ZERO)
    else $error("temperature low byte pad bits not zero");

  a_local_high_byte: assert property (
    rd_en_i && rd_addr_i == `ADDR_LOCAL_HIGH |=> rd_data_o == $past(local_temp_reg[10:3]))
    else $error("local high byte read wrong");

  a_read_clears: assert property (
    status_read && cond == `RESET_ALARMS |=> alarm_reg == `RESET_ALARMS)
    else $error("status read did not clear alarms");

  a_fault_resets: assert property (
    cond != `RESET_ALARMS |=> (alarm_reg & $past(cond)) == $past(cond))
    else $error("present fault not flagged");

  a_corrupt_sets: assert property (
    nvm_write_done_i && nvm_write_error_i |=> corrupt_reg [*2])
    else $error("program corrupt flag not set");

  a_corrupt_holds: assert property (
    corrupt_reg && status_read |=> corrupt_reg && rd_data_o[`BIT_PROG_CORRUPT])
    else $error("program corrupt flag cleared by read");

  a_diode_no_alert: assert property (
    !alarm_reg[`BIT_LOCAL_HIGH] && !alarm_reg[`BIT_REMOTE_HIGH] |-> !alert_o)
    else $error("alert raised without a high alarm");

  a_local_equal_clear: assert property (
    status_read && local_temp_reg == {setpoint_i.local_high, `SETPOINT_FRAC}
    |=> !alarm_reg[`BIT_LOCAL_HIGH])
    else $error("local high alarm set at equality");

  a_local_ot_strict: assert property (
    $signed(local_temp_reg) > $signed({setpoint_i.local_ot, `SETPOINT_FRAC}) |=> alarm_reg[`BIT_LOCAL_OT])
    else $error("local overtemperature alarm missed");

  a_pair_atomic: assert property (
    s_fan_high_read ##1 s_fan_low_read |=> rd_data_o == $past(fan2_count_reg[7:0], 2))
    else $error("fan2 byte pair torn");

  sequence s_remote_high_read;
    rd_en_i && rd_addr_i == `ADDR_REMOTE_HIGH;
  endsequence

  sequence s_remote_low_read;
    rd_en_i && rd_addr_i == `ADDR_REMOTE_LOW;
  endsequence

  a_remote_pair_atomic: assert property (
    s_remote_high_read ##1 s_remote_low_read
    |=> rd_data_o == {$past(remote_temp_reg[2:0], 2), `LOW_PAD_ZERO})
    else $error("remote byte pair torn");

  a_remote_low_live: assert property (
    rd_en_i && rd_addr_i == `ADDR_REMOTE_LOW && !snap_valid_reg[1]
    |=> rd_data_o == {$past(remote_temp_reg[2:0]), `LOW_PAD_ZERO})
    else $error("remote low byte read wrong");

  a_local_low_live: assert property (
    rd_en_i && rd_addr_i == `ADDR_LOCAL_LOW && !snap_valid_reg[2]
    |=> rd_data_o == {$past(local_temp_reg[2:0]), `LOW_PAD_ZERO})
    else $error("local low byte read wrong");

  a_status_readback: assert property (
    status_read |=> rd_data_o == $past({corrupt_reg, alarm_reg}))
    else $error("status byte read wrong");

  a_diode_sets: assert property (
    fault_i.remote_diode_fault |=> alarm_reg[`BIT_DIODE_FAULT])
    else $error("remote diode fault not flagged");

  a_local_high_strict: assert property (
    $signed(local_temp_reg) > $signed({setpoint_i.local_high, `SETPOINT_FRAC}) |=> alarm_reg[`BIT_LOCAL_HIGH])
    else $error("local high alarm missed");

  a_remote_high_strict: assert property (
    $signed(remote_temp_reg) > $signed({setpoint_i.remote_high, `SETPOINT_FRAC}) |=> alarm_reg[`BIT_REMOTE_HIGH])
    else $error("remote high alarm missed");

  a_remote_ot_strict: assert property (
    $signed(remote_temp_reg) > $signed({setpoint_i.remote_ot, `SETPOINT_FRAC}) |=> alarm_reg[`BIT_REMOTE_OT])
    else $error("remote overtemperature alarm missed");

  a_fan_flags_set: assert property (
    fault_i.fan_fail != 2'b00 |=> (alarm_reg[1:0] & $past(fault_i.fan_fail)) == $past(fault_i.fan_fail))
    else $error("fan failure not flagged");

  a_read_answers: assert property (
    rd_en_i |=> rd_valid_o)
    else $error("read request not answered");

  a_read_idle_zero: assert property (
    !rd_en_i |=> !rd_valid_o && rd_data_o == `RESET_BYTE)
    else $error("read data not idle");

endmodule

/* sim/temp_tach_host.sv */
`timescale 1ns/1ns
module temp_tach_host (
  // Clock
  input  wire logic       core_clk_i,
  // Register read port
  output logic            rd_en_o,
  output logic      [7:0] rd_addr_o,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i
);
  initial begin
    rd_en_o   = 1'b0;
    rd_addr_o = 8'hff;
  end

  // Callers read the status byte only when ready to handle every flag it carries
  task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge core_clk_i);
    rd_en_o   = 1'b1;
    rd_addr_o = addr;
    @(negedge core_clk_i);
    rd_en_o   = 1'b0;
    // Scrambled so a stale address can never match by luck
    rd_addr_o = ~addr;
    ok        = rd_valid_i;
    data      = rd_data_i;
  endtask

  // High byte then low byte on consecutive edges, as a burst from the host
  task automatic read_pair(input logic [7:0] addr, output logic [7:0] hi, output logic [7:0] lo);
    @(negedge core_clk_i);
    rd_en_o   = 1'b1;
    rd_addr_o = addr;
    @(negedge core_clk_i);
    rd_addr_o = addr + 8'h01;
    hi        = rd_data_i;
    @(negedge core_clk_i);
    rd_en_o   = 1'b0;
    rd_addr_o = ~addr;
    lo        = rd_data_i;
  endtask
endmodule

/* sim/temp_tach_readout_status_test.sv */
`timescale 1ns/1ns
module temp_tach_readout_status_test
  import temp_tach_pkg::*;
();
  logic        core_clk   = 1'b0;
  logic        rst_n      = 1'b0;
  meas_t       meas       = '0;
  logic        meas_valid = 1'b0;
  setpoint_t   setpoint   = '0;
  fault_t      fault      = '0;
  logic        nvm_done   = 1'b0;
  logic        nvm_err    = 1'b0;
  logic        nvm_boot   = 1'b0;
  logic        rd_en;
  logic  [7:0] rd_addr;
  logic  [7:0] rd_data;
  logic        rd_valid;
  logic        alert;
  logic [31:0] seed       = 32'hb477_6af0;
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #5 core_clk = ~core_clk;

  temp_tach_readout_status i_temp_tach_readout_status (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .meas_i(meas), .meas_valid_i(meas_valid),
    .setpoint_i(setpoint), .fault_i(fault), .nvm_write_done_i(nvm_done),
    .nvm_write_error_i(nvm_err), .nvm_boot_corrupt_i(nvm_boot), .rd_en_i(rd_en),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .alert_o(alert));

  temp_tach_host i_temp_tach_host (
    .core_clk_i(core_clk), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .rd_valid_i(rd_valid));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Temperatures sit left-aligned so the low byte carries the fraction over five zero bits
  function automatic logic [7:0] reg_byte(input meas_t m, input int k, input bit lo);
    logic [15:0] v;
    case (k)
      0: v = m.fan2_count;
      1: v = {m.remote_temp, 5'h00};
      default: v = {m.local_temp, 5'h00};
    endcase
    return lo ? v[7:0] : v[15:8];
  endfunction

  function automatic meas_t rnd_meas();
    logic [63:0] r;
    r[63:32] = rnd();
    r[31:0]  = rnd();
    return r[37:0];
  endfunction

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_temp_tach_host.read(addr, d, ok);
    check({7'h00, ok}, 8'h01, "answer strobe");
    check(d, exp, "read data");
  endtask

  // Waits until the alarm stage has seen the new values
  task automatic load(input meas_t m);
    @(negedge core_clk);
    meas       = m;
    meas_valid = 1'b1;
    @(negedge core_clk);
    meas_valid = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic do_reset(input logic boot);
    @(negedge core_clk);
    rst_n    = 1'b0;
    nvm_boot = boot;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
  endtask

  task automatic pulse_nvm(input logic err);
    @(negedge core_clk);
    nvm_err  = err;
    nvm_done = 1'b1;
    @(negedge core_clk);
    nvm_done = 1'b0;
    @(negedge core_clk);
  endtask

  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    meas_t      m;
    meas_t      m2;
    logic [7:0] s;
    logic [2:0] f;
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ok;
    do_reset(1'b0);
    for (int a = 8'h54; a <= 8'h5b; a++) begin
      rd_check(a[7:0], 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 3; k++) begin
        m = (i == 0) ? {16'hffff, 11'h400, 11'h3ff} : rnd_meas();
        load(m);
        rd_check(8'h54 + 8'(2 * k), reg_byte(m, k, 1'b0));
        m2 = rnd_meas();
        load(m2);
        rd_check(8'h55 + 8'(2 * k), reg_byte(m, k, 1'b1));
        rd_check(8'h55 + 8'(2 * k), reg_byte(m2, k, 1'b1));
      end
    end
    // Update lands on the very edge of the high read; the low byte must still match it
    for (int k = 0; k < 3; k++) begin
      m  = rnd_meas();
      m2 = rnd_meas();
      load(m);
      fork
        i_temp_tach_host.read_pair(8'h54 + 8'(2 * k), hi, lo);
        load(m2);
      join
      check(hi, reg_byte(m, k, 1'b0), "pair high byte");
      check(lo, reg_byte(m, k, 1'b1), "pair low byte");
    end
    s        = 8'(rnd());
    setpoint = {4{s}};
    m        = '0;
    m.local_temp  = {s, 3'h0};
    m.remote_temp = {s, 3'h0};
    load(m);
    // Earlier scenarios leave sticky alarms; cleared here with temperatures on the set points
    i_temp_tach_host.read(8'h5a, hi, ok);
    rd_check(8'h5a, 8'h00);
    m.local_temp = {s, 3'h0} + 11'h001;
    load(m);
    rd_check(8'h5a, 8'h30);
    check({7'h00, alert}, 8'h01, "alert level");
    m.local_temp  = {s, 3'h0};
    m.remote_temp = {s, 3'h0} + 11'h001;
    load(m);
    rd_check(8'h5a, 8'h3c);
    rd_check(8'h5a, 8'h0c);
    check({7'h00, alert}, 8'h01, "alert level");
    m.remote_temp = {s, 3'h0};
    load(m);
    rd_check(8'h5a, 8'h0c);
    rd_check(8'h5a, 8'h00);
    check({7'h00, alert}, 8'h00, "alert level");
    for (int k = 0; k < 3; k++) begin
      f     = 3'b001 << k;
      fault = f;
      repeat (2) @(negedge core_clk);
      check({7'h00, alert}, 8'h00, "alert level");
      fault = '0;
      rd_check(8'h5a, {1'b0, f[2], 4'h0, f[1:0]});
      rd_check(8'h5a, 8'h00);
    end
    pulse_nvm(1'b0);
    rd_check(8'h5a, 8'h00);
    pulse_nvm(1'b1);
    rd_check(8'h5a, 8'h80);
    rd_check(8'h5a, 8'h80);
    // Reset zeroes the temperatures, so zero set points keep every alarm quiet afterwards
    setpoint = '0;
    do_reset(1'b1);
    rd_check(8'h5a, 8'h80);
    do_reset(1'b0);
    rd_check(8'h5a, 8'h00);
    finish_test();
  end
endmodule
